// ---- core/gfo_params.svh ----
// Constants for the pin function and fault output block: register offsets,
// field positions, reset values and function codes.
// Assumes inclusion by bare name from the design files only.
`ifndef GFO_PARAMS_SVH
`define GFO_PARAMS_SVH

// ==========================================================================
// Register offsets on the configuration port
`define GFO_OFF_PIN_INPUT_LEVELS    8'h1E
`define GFO_OFF_FAULT_A_SEL_LOW     8'h36
`define GFO_OFF_FAULT_A_SEL_HIGH    8'h37
`define GFO_OFF_FAULT_B_SEL_LOW     8'h38
`define GFO_OFF_FAULT_B_SEL_HIGH    8'h39
`define GFO_OFF_FAULT_OC_SEL        8'h3A
`define GFO_OFF_PIN_OUTPUT_LEVELS   8'h3E
`define GFO_OFF_PIN_FUNC_CFG_0      8'h3F
`define GFO_OFF_PIN_FUNC_CFG_1      8'h40
`define GFO_OFF_PIN_FUNC_CFG_2      8'h41
`define GFO_OFF_PIN_DRIVE_TYPE      8'h42

// ==========================================================================
// Field positions inside the high selection byte of each fault output
`define GFO_HI_SEL_LSB              0
`define GFO_HI_OV_EN_BIT            4
`define GFO_HI_UV_EN_BIT            5
`define GFO_HI_EW_EN_BIT            6
`define GFO_HI_POLARITY_BIT         7
// Field positions inside the overcurrent select byte
`define GFO_OC_SEL_A_BIT            0
`define GFO_OC_SEL_B_BIT            1

// ==========================================================================
// Reset values
`define GFO_RST_BYTE                8'h00
`define GFO_RST_FUNC_CFG            24'h00_0000
`define GFO_RST_PINS                8'h00

// ==========================================================================
// Pin function codes
`define GFO_CODE_LOGIC_IN           3'h0
`define GFO_CODE_LOGIC_OUT          3'h1
`define GFO_CODE_FAULT_B            3'h2
`define GFO_CODE_FAULT_A            3'h3
`define GFO_CODE_ANY_FAULT          3'h4
`define GFO_CODE_OVERCURRENT        3'h5
`define GFO_CODE_MR_WDO             3'h6
`define GFO_CODE_MISC               3'h7

`endif

// ---- core/gfo_pkg.sv ----
// Types shared by the pin function and fault output block.
// Assumes nothing of its surroundings; holds types only.
package gfo_pkg;

  // ========================================================================
  // Resolved role of one pin, decoded from its function code and position.
  typedef enum logic [3:0] {
    GFO_ROLE_LOGIC_IN   = 4'h0,
    GFO_ROLE_LOGIC_OUT  = 4'h1,
    GFO_ROLE_FAULT_B    = 4'h3,
    GFO_ROLE_FAULT_A    = 4'h2,
    GFO_ROLE_PWRUP_FLT  = 4'h6,
    GFO_ROLE_ANY_FAULT  = 4'h7,
    GFO_ROLE_SEC_RESET  = 4'h5,
    GFO_ROLE_OVERCUR    = 4'h4,
    GFO_ROLE_MAN_RESET  = 4'hC,
    GFO_ROLE_WDOG_OUT   = 4'hD,
    GFO_ROLE_WDOG_KICK  = 4'hF,
    GFO_ROLE_NONE       = 4'hE,
    GFO_ROLE_EXT_FAULT  = 4'hA,
    GFO_ROLE_SEQ_EN     = 4'hB,
    GFO_ROLE_MARGIN     = 4'h9
  } gfo_role_t;

  // ========================================================================
  // Whole state of the top module.
  typedef struct packed {
    logic [7:0]  pin_in;
    logic [7:0]  out_lvl;
    logic [23:0] func_cfg;
    logic [7:0]  drive_od;
    logic [7:0]  fa_lo;
    logic [7:0]  fa_hi;
    logic [7:0]  fb_lo;
    logic [7:0]  fb_hi;
    logic [7:0]  oc_sel;
    logic [7:0]  rdata;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic        fault_a;
    logic        fault_b;
    logic        any_fault_n;
    logic        man_reset_n;
    logic        wdog_kick;
    logic        seq_enable;
    logic        margin_n;
    logic        ext_fault;
  } gfo_state_t;

endpackage

// ---- core/gfo_fault_eval.sv ----
// One fault output's cause combiner: selected inputs, enabled threshold types
// and the optional secondary overcurrent comparison, all ORed together.
// Assumes threshold flags are already synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none

module gfo_fault_eval #(
  parameter int NMON = 12
) (
  input  wire logic [NMON-1:0] sel_i,
  input  wire logic            ov_en_i,
  input  wire logic            uv_en_i,
  input  wire logic            ew_en_i,
  input  wire logic            oc_en_i,
  input  wire logic [NMON-1:0] ov_i,
  input  wire logic [NMON-1:0] uv_i,
  input  wire logic [NMON-1:0] ew_i,
  input  wire logic            oc2_i,
  output logic                 fault_o
);

  logic [NMON-1:0] cause;

  // ========================================================================
  // Per-input causes gated by the enabled threshold types.
  assign cause = (ov_i & {NMON{ov_en_i}}) |
                 (uv_i & {NMON{uv_en_i}}) |
                 (ew_i & {NMON{ew_en_i}});

  assign fault_o = (|(sel_i & cause)) | (oc_en_i & oc2_i);

endmodule

`default_nettype wire

// ---- core/gfo_top.sv ----
// Eight configurable pins with function select, drive type, input and output
// state registers, and the two programmable fault outputs.
// Assumes a byte-wide configuration port synchronous to core_clk_i, and
// threshold flags, fault sources and pin levels synchronous to it as well.
//
// Overview of operation
// - Fault output asserts on any selected input.
// - Secondary overcurrent can also assert fault outputs.
// - Fault outputs ignore critical-fault handling entirely.
// - Input-state register returns sampled pin levels.
// - Output-state register drives pins set as outputs.
// - Pins one and two codes in first byte; pin three code starts there.
// - Pins four to eight codes in later bytes.
// - Drive-type bit picks push-pull or open-drain; external-fault pins are always open-drain.
// - Code 000 input, code 001 output.
// - Code 010 fault B, 011 fault A/powerup.
// - Code 100 any-fault or secondary reset.
// - Any-fault low on fault A, fault B, powerup fault or sequence fault.
// - Code 101 puts overcurrent flag on pin.
// - Code 110 manual reset in or watchdog out.
// - Code 111 kick, external fault, enable, margin.
// - Sequence-enable pin level enables secondary group.
// - Fault A selects inputs one to twelve.
// - Fault A threshold-type enables in second byte.
// - Fault A polarity bit in second byte.
// - Fault B selects inputs one to twelve.
// - Output levels load power-on default copy.
// - Overcurrent pin reflects primary comparator only.
`timescale 1ns/1ps
`default_nettype none

`include "gfo_params.svh"

module gfo_top
  import gfo_pkg::*;
#(
  parameter int NPIN = 8,
  parameter int NMON = 12
) (
  input  wire logic            core_clk_i,
  input  wire logic            rst_i,
  input  wire logic [7:0]      reg_addr_i,
  input  wire logic            reg_wr_i,
  input  wire logic [7:0]      reg_wdata_i,
  input  wire logic            reg_rd_i,
  output logic      [7:0]      reg_rdata_o,
  input  wire logic [7:0]      flash_out_levels_i,
  input  wire logic [NPIN-1:0] pin_i,
  output logic      [NPIN-1:0] pin_o,
  output logic      [NPIN-1:0] pin_oe_o,
  input  wire logic [NMON-1:0] mon_ov_i,
  input  wire logic [NMON-1:0] mon_uv_i,
  input  wire logic [NMON-1:0] mon_ew_i,
  input  wire logic            oc_secondary_i,
  input  wire logic            oc_primary_i,
  input  wire logic            powerup_fault_out_i,
  input  wire logic            seq_fault_i,
  input  wire logic            secondary_reset_out_i,
  input  wire logic            watchdog_out_n_i,
  input  wire logic            ext_fault_drive_i,
  output logic                 fault_out_a_o,
  output logic                 fault_out_b_o,
  output logic                 any_fault_n_o,
  output logic                 manual_reset_in_n_o,
  output logic                 watchdog_kick_in_o,
  output logic                 secondary_sequence_enable_o,
  output logic                 margin_in_n_o,
  output logic                 external_fault_in_o
);

  // ========================================================================
  // Pin role decoding, used for drive and for pin-sourced inputs.
  function automatic gfo_role_t pin_role(input int unsigned pin, input logic [2:0] code);
    gfo_role_t r;
    r = GFO_ROLE_NONE;
    case (code)
      `GFO_CODE_LOGIC_IN:   r = GFO_ROLE_LOGIC_IN;
      `GFO_CODE_LOGIC_OUT:  r = GFO_ROLE_LOGIC_OUT;
      `GFO_CODE_FAULT_B:    r = GFO_ROLE_FAULT_B;
      `GFO_CODE_FAULT_A: begin
        r = (pin == 2 || pin == 7) ? GFO_ROLE_PWRUP_FLT : GFO_ROLE_FAULT_A;
      end
      `GFO_CODE_ANY_FAULT: begin
        r = (pin == 1 || pin == 5 || pin == 7) ? GFO_ROLE_SEC_RESET
                                               : GFO_ROLE_ANY_FAULT;
      end
      `GFO_CODE_OVERCURRENT: r = GFO_ROLE_OVERCUR;
      // odd pins reset in, even pins watchdog out.
      `GFO_CODE_MR_WDO: begin
        r = (pin[0] == 1'b0) ? GFO_ROLE_MAN_RESET : GFO_ROLE_WDOG_OUT;
      end
      `GFO_CODE_MISC: begin
        case (pin)
          0:       r = GFO_ROLE_WDOG_KICK;
          3, 7:    r = GFO_ROLE_EXT_FAULT;
          4, 6:    r = GFO_ROLE_SEQ_EN;
          5:       r = GFO_ROLE_MARGIN;
          default: r = GFO_ROLE_NONE;
        endcase
      end
      default: r = GFO_ROLE_NONE;
    endcase
    return r;
  endfunction

  gfo_state_t      q;
  gfo_state_t      d;
  logic [1:0]      fault_raw;
  logic [NMON-1:0] sel_a;
  logic [NMON-1:0] sel_b;

  // ========================================================================
  // Cause selection for both fault outputs.
  // fault A covers inputs one to twelve.
  assign sel_a = {q.fa_hi[`GFO_HI_SEL_LSB +: 4], q.fa_lo};
  // fault B low byte, extra byte for inputs nine to twelve.
  assign sel_b = {q.fb_hi[`GFO_HI_SEL_LSB +: 4], q.fb_lo};

  // Both combiners are the same logic; a loop keeps them identical.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_fault
      gfo_fault_eval #(
        .NMON (NMON)
      ) u_eval (
        .sel_i   ((gi == 0) ? sel_a : sel_b),
        .ov_en_i ((gi == 0) ? q.fa_hi[`GFO_HI_OV_EN_BIT] : q.fb_hi[`GFO_HI_OV_EN_BIT]),
        .uv_en_i ((gi == 0) ? q.fa_hi[`GFO_HI_UV_EN_BIT] : q.fb_hi[`GFO_HI_UV_EN_BIT]),
        .ew_en_i ((gi == 0) ? q.fa_hi[`GFO_HI_EW_EN_BIT] : q.fb_hi[`GFO_HI_EW_EN_BIT]),
        .oc_en_i ((gi == 0) ? q.oc_sel[`GFO_OC_SEL_A_BIT] : q.oc_sel[`GFO_OC_SEL_B_BIT]),
        .ov_i    (mon_ov_i),
        .uv_i    (mon_uv_i),
        .ew_i    (mon_ew_i),
        .oc2_i   (oc_secondary_i),
        .fault_o (fault_raw[gi])
      );
    end
  endgenerate

  // ========================================================================
  // Next-state logic for the whole block.
  always_comb begin
    gfo_role_t  role;
    logic       lvl;
    logic       drv;
    logic       od;
    logic [2:0] code;
    role = GFO_ROLE_NONE;
    lvl  = 1'b0;
    drv  = 1'b0;
    od   = 1'b0;
    code = 3'h0;
    d    = q;

    d.pin_in = pin_i;

    // Register writes; the input-state register ignores writes.
    if (reg_wr_i) begin
      case (reg_addr_i)
        `GFO_OFF_FAULT_A_SEL_LOW:   d.fa_lo    = reg_wdata_i;
        `GFO_OFF_FAULT_A_SEL_HIGH:  d.fa_hi    = reg_wdata_i;
        `GFO_OFF_FAULT_B_SEL_LOW:   d.fb_lo    = reg_wdata_i;
        `GFO_OFF_FAULT_B_SEL_HIGH:  d.fb_hi    = reg_wdata_i;
        `GFO_OFF_FAULT_OC_SEL:      d.oc_sel   = reg_wdata_i;
        `GFO_OFF_PIN_OUTPUT_LEVELS: d.out_lvl  = reg_wdata_i;
        `GFO_OFF_PIN_FUNC_CFG_0:    d.func_cfg[7:0]   = reg_wdata_i;
        `GFO_OFF_PIN_FUNC_CFG_1:    d.func_cfg[15:8]  = reg_wdata_i;
        `GFO_OFF_PIN_FUNC_CFG_2:    d.func_cfg[23:16] = reg_wdata_i;
        `GFO_OFF_PIN_DRIVE_TYPE:    d.drive_od = reg_wdata_i;
        default: begin
        end
      endcase
    end

    // Register reads; unmapped offsets answer zero.
    if (reg_rd_i) begin
      case (reg_addr_i)
        `GFO_OFF_PIN_INPUT_LEVELS:  d.rdata = q.pin_in;
        `GFO_OFF_FAULT_A_SEL_LOW:   d.rdata = q.fa_lo;
        `GFO_OFF_FAULT_A_SEL_HIGH:  d.rdata = q.fa_hi;
        `GFO_OFF_FAULT_B_SEL_LOW:   d.rdata = q.fb_lo;
        `GFO_OFF_FAULT_B_SEL_HIGH:  d.rdata = q.fb_hi;
        `GFO_OFF_FAULT_OC_SEL:      d.rdata = q.oc_sel;
        `GFO_OFF_PIN_OUTPUT_LEVELS: d.rdata = q.out_lvl;
        `GFO_OFF_PIN_FUNC_CFG_0:    d.rdata = q.func_cfg[7:0];
        `GFO_OFF_PIN_FUNC_CFG_1:    d.rdata = q.func_cfg[15:8];
        `GFO_OFF_PIN_FUNC_CFG_2:    d.rdata = q.func_cfg[23:16];
        `GFO_OFF_PIN_DRIVE_TYPE:    d.rdata = q.drive_od;
        default:                    d.rdata = `GFO_RST_BYTE;
      endcase
    end

    // Fault levels are kept active-high internally; polarity is applied
    // only at the pin so status outputs stay easy to read.
    d.fault_a = fault_raw[0];
    d.fault_b = fault_raw[1];
    // any-fault low on either fault output, a powerup fault or a sequence fault.
    d.any_fault_n = ~(fault_raw[0] | fault_raw[1] | powerup_fault_out_i | seq_fault_i);

    // Pin-sourced inputs start from their idle levels each cycle.
    d.man_reset_n = 1'b1;
    d.wdog_kick   = 1'b0;
    d.seq_enable  = 1'b0;
    d.margin_n    = 1'b1;
    d.ext_fault   = 1'b0;

    for (int unsigned p = 0; p < NPIN; p++) begin
      code = q.func_cfg[3*p +: 3];
      role = pin_role(p, code);
      lvl  = 1'b0;
      drv  = 1'b1;
      od   = q.drive_od[p];
      case (role)
        GFO_ROLE_LOGIC_OUT: lvl = q.out_lvl[p];
        GFO_ROLE_FAULT_A:   lvl = q.fa_hi[`GFO_HI_POLARITY_BIT] ? fault_raw[0] : ~fault_raw[0];
        // fault B polarity in its extra byte.
        GFO_ROLE_FAULT_B:   lvl = q.fb_hi[`GFO_HI_POLARITY_BIT] ? fault_raw[1] : ~fault_raw[1];
        GFO_ROLE_PWRUP_FLT: lvl = powerup_fault_out_i;
        GFO_ROLE_ANY_FAULT: lvl = d.any_fault_n;
        GFO_ROLE_SEC_RESET: lvl = secondary_reset_out_i;
        GFO_ROLE_OVERCUR:   lvl = ~oc_primary_i;
        GFO_ROLE_WDOG_OUT:  lvl = watchdog_out_n_i;
        GFO_ROLE_EXT_FAULT: begin
          // Shared line: always open drain so other parties may pull it low.
          lvl = ~ext_fault_drive_i;
          od  = 1'b1;
          if (!q.pin_in[p]) begin
            d.ext_fault = 1'b1;
          end
        end
        GFO_ROLE_MAN_RESET: begin
          drv = 1'b0;
          if (!q.pin_in[p]) begin
            d.man_reset_n = 1'b0;
          end
        end
        GFO_ROLE_WDOG_KICK: begin
          drv = 1'b0;
          d.wdog_kick = q.pin_in[p];
        end
        GFO_ROLE_SEQ_EN: begin
          drv = 1'b0;
          if (q.pin_in[p]) begin
            d.seq_enable = 1'b1;
          end
        end
        GFO_ROLE_MARGIN: begin
          drv = 1'b0;
          if (!q.pin_in[p]) begin
            d.margin_n = 1'b0;
          end
        end
        default: drv = 1'b0;
      endcase
      d.pin_out[p] = drv & lvl;
      d.pin_oe[p]  = drv & ~(od & lvl);
    end

    // output levels take the power-on default copy.
    if (rst_i) begin
      d          = '0;
      d.out_lvl  = flash_out_levels_i;
      d.func_cfg = `GFO_RST_FUNC_CFG;
      d.pin_out  = `GFO_RST_PINS;
      d.pin_oe   = `GFO_RST_PINS;
      d.any_fault_n = 1'b1;
      d.man_reset_n = 1'b1;
      d.margin_n    = 1'b1;
    end
  end

  // ========================================================================
  // Single state register; reset is folded into the next-state logic.
  always_ff @(posedge core_clk_i) begin
    q <= d;
  end

  // Outputs come straight from the state register.
  assign reg_rdata_o                 = q.rdata;
  assign pin_o                       = q.pin_out;
  assign pin_oe_o                    = q.pin_oe;
  assign fault_out_a_o               = q.fault_a;
  assign fault_out_b_o               = q.fault_b;
  assign any_fault_n_o               = q.any_fault_n;
  assign manual_reset_in_n_o         = q.man_reset_n;
  assign watchdog_kick_in_o          = q.wdog_kick;
  assign secondary_sequence_enable_o = q.seq_enable;
  assign margin_in_n_o               = q.margin_n;
  assign external_fault_in_o         = q.ext_fault;

endmodule

`default_nettype wire

// ---- verification/gfo_board_model.sv ----
// Board model for the eight configurable pins: a pull-up on every pin and an
// external driver steered by the bench.
// Assumes the design's pin_o/pin_oe_o; a driving design wins over the board.
`timescale 1ns/1ps
`default_nettype none
module gfo_board_model (
  input  wire logic [7:0] dut_o_i,
  input  wire logic [7:0] dut_oe_i,
  input  wire logic [7:0] drv_val_i,
  input  wire logic [7:0] drv_en_i,
  output logic      [7:0] lvl_o
);
  // ====
  // Wire resolution
  // released pull-up
  // A released pin goes to the pull-up, so a stale level can never pass for a driven one.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lvl_o[i] = dut_oe_i[i] ? dut_o_i[i] : (drv_en_i[i] ? drv_val_i[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

// ---- verification/gfo_top_sva.sv ----
// Port-level checker for gfo_top, attached by bind.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module gfo_top_sva #(
  parameter int NPIN = 8,
  parameter int NMON = 12
) (
  input wire logic            core_clk_i,
  input wire logic            rst_i,
  input wire logic [7:0]      reg_addr_i,
  input wire logic            reg_wr_i,
  input wire logic [7:0]      reg_wdata_i,
  input wire logic            reg_rd_i,
  input wire logic [7:0]      reg_rdata_o,
  input wire logic [NPIN-1:0] pin_i,
  input wire logic [NMON-1:0] mon_ov_i,
  input wire logic [NMON-1:0] mon_uv_i,
  input wire logic [NMON-1:0] mon_ew_i,
  input wire logic            oc_secondary_i,
  input wire logic            powerup_fault_out_i,
  input wire logic            seq_fault_i,
  input wire logic            fault_out_a_o,
  input wire logic            fault_out_b_o,
  input wire logic            any_fault_n_o,
  input wire logic            manual_reset_in_n_o,
  input wire logic            watchdog_kick_in_o,
  input wire logic            secondary_sequence_enable_o,
  input wire logic            margin_in_n_o,
  input wire logic            external_fault_in_o
);
  // ====
  // Helpers
  logic [NPIN-1:0] pin_d1_q;
  logic [NPIN-1:0] pin_d2_q;
  logic            cause;
  // Pin levels two edges back, the age at which pin roles act on them.
  always_ff @(posedge core_clk_i) begin
    pin_d1_q <= pin_i;
    pin_d2_q <= pin_d1_q;
  end
  // Without a flag or the secondary compare no fault output may rise.
  assign cause = |{mon_ov_i, mon_uv_i, mon_ew_i, oc_secondary_i};
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_lvl_wr;
    reg_wr_i && reg_addr_i == 8'h3E;
  endsequence
  sequence s_lvl_rd;
    reg_rd_i && !reg_wr_i && reg_addr_i == 8'h3E;
  endsequence
  // ====
  // Register port
  a_lvl_read_back: assert property (s_lvl_wr ##1 s_lvl_rd |=>
    reg_rdata_o == $past(reg_wdata_i, 2)) else $error("output level read-back wrong");
  a_input_read: assert property (reg_rd_i && reg_addr_i == 8'h1E && !$past(rst_i) |=>
    reg_rdata_o == $past(pin_i, 2)) else $error("input level read wrong");
  a_unmapped_zero: assert property (reg_rd_i && !(reg_addr_i inside
    {8'h1E, [8'h36:8'h3A], [8'h3E:8'h42]}) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  // ====
  // Fault outputs
  a_fault_no_cause: assert property (!cause |=> !fault_out_a_o && !fault_out_b_o)
    else $error("fault output without cause");
  a_fault_rise_cause: assert property ($rose(fault_out_a_o) || $rose(fault_out_b_o)
    |-> $past(cause)) else $error("fault rose without cause");
  a_any_fault_or: assert property (!$past(rst_i) |-> any_fault_n_o == !(fault_out_a_o
    || fault_out_b_o || $past(powerup_fault_out_i) || $past(seq_fault_i)))
    else $error("any-fault indicator wrong");
  // ====
  // Pin-derived inputs
  a_mr_from_pin: assert property (!manual_reset_in_n_o |->
    !(pin_d2_q[0] && pin_d2_q[2] && pin_d2_q[4] && pin_d2_q[6]))
    else $error("manual reset without a low pin");
  a_kick_from_pin: assert property (watchdog_kick_in_o |-> pin_d2_q[0])
    else $error("kick without pin level");
  a_margin_from_pin: assert property (!margin_in_n_o |-> !pin_d2_q[5])
    else $error("margin without low pin");
  a_seq_en_pin: assert property (secondary_sequence_enable_o |-> pin_d2_q[4] || pin_d2_q[6])
    else $error("sequence enable without pin level");
  a_ext_fault_pin: assert property (external_fault_in_o |-> !(pin_d2_q[3] && pin_d2_q[7]))
    else $error("external fault without low pin");
endmodule
bind gfo_top gfo_top_sva #(.NPIN(NPIN), .NMON(NMON)) gfo_top_sva_i (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pin_i(pin_i),
  .mon_ov_i(mon_ov_i), .mon_uv_i(mon_uv_i), .mon_ew_i(mon_ew_i),
  .oc_secondary_i(oc_secondary_i), .powerup_fault_out_i(powerup_fault_out_i),
  .seq_fault_i(seq_fault_i), .fault_out_a_o(fault_out_a_o), .fault_out_b_o(fault_out_b_o),
  .any_fault_n_o(any_fault_n_o), .manual_reset_in_n_o(manual_reset_in_n_o),
  .watchdog_kick_in_o(watchdog_kick_in_o), .margin_in_n_o(margin_in_n_o),
  .secondary_sequence_enable_o(secondary_sequence_enable_o),
  .external_fault_in_o(external_fault_in_o));
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for gfo_top: register accesses, pin roles, fault outputs.
// Assumes the board model for pin levels; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rst;
  logic        wr;
  logic        rd;
  logic [7:0]  addr, wdata, rdata, flash, pins, po, poe, dv, de;
  logic [11:0] ov, uv, ew;
  logic        oc2, oc1, pu, sf, r2, watchdog_out_n, xf;
  logic        fa, fb, afn, mrn, kick, sen, mgn, xin;
  int          errors = 0;
  int          total_checks = 0;
  logic [7:0]  offs [10] = '{8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3F, 8'h40, 8'h41,
                             8'h42, 8'h50};
  gfo_top gfo_top_i (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .flash_out_levels_i(flash),
    .pin_i(pins), .pin_o(po), .pin_oe_o(poe), .mon_ov_i(ov), .mon_uv_i(uv), .mon_ew_i(ew),
    .oc_secondary_i(oc2), .oc_primary_i(oc1), .powerup_fault_out_i(pu), .seq_fault_i(sf),
    .secondary_reset_out_i(r2), .watchdog_out_n_i(watchdog_out_n), .ext_fault_drive_i(xf),
    .fault_out_a_o(fa), .fault_out_b_o(fb), .any_fault_n_o(afn),
    .manual_reset_in_n_o(mrn), .watchdog_kick_in_o(kick), .margin_in_n_o(mgn),
    .secondary_sequence_enable_o(sen), .external_fault_in_o(xin));
  gfo_board_model gfo_board_model_i (.dut_o_i(po), .dut_oe_i(poe), .drv_val_i(dv),
    .drv_en_i(de), .lvl_o(pins));
  // Free-running 50 MHz core clock.
  always #10 clk = ~clk;
  // ====
  // Access tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Strobes stay up between back-to-back accesses so no signal is set twice at one edge.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    {addr, wdata, wr, rd} = {a, d, 2'b10};
    @(negedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    {addr, wr, rd} = {a, 2'b01};
    @(negedge clk);
    chk($sformatf("reg %h", a), e, rdata);
  endtask
  task automatic cfg(input logic [23:0] c);
    wr_reg(8'h3F, c[7:0]);
    wr_reg(8'h40, c[15:8]);
    wr_reg(8'h41, c[23:16]);
  endtask
  // Three cycles cover the two-cycle lag of pin-derived outputs.
  task automatic settle();
    {wr, rd} = 2'b00;
    repeat (3) @(negedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Cuts a hang short well inside the cycle budget.
  initial begin
    #1_000_000;
    errors++;
    end_of_test();
  end
  // ====
  // Main sequence
  initial begin
    {rst, wr, rd, addr, wdata, dv, de, ov, uv, ew} = {1'b1, 70'h0};
    {oc2, oc1, pu, sf, r2, xf, watchdog_out_n, flash} = {7'b0000001, 8'hA5};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd_reg(8'h3E, 8'hA5);
    foreach (offs[i]) rd_reg(offs[i], 8'h00);
    chk("pin_oe", 8'h00, poe);
    {de, dv} = 16'hFF3C;
    wr_reg(8'h1E, 8'hFF);
    settle();
    rd_reg(8'h1E, 8'h3C);
    de = 8'h00;
    wr_reg(8'h3E, 8'hFF);
    // One pin at a time as output proves where each code field sits.
    for (int n = 0; n < 8; n++) begin
      cfg(24'h1 << (3 * n));
      settle();
      chk("single out", 8'h1 << n, poe);
    end
    cfg({8{3'h1}});
    wr_reg(8'h42, 8'h0F);
    wr_reg(8'h3E, 8'h5A);
    rd_reg(8'h3E, 8'h5A);
    settle();
    chk("drive oe", 8'hF5, poe);
    chk("drive lvl", 8'h50, po & poe);
    rd_reg(8'h1E, 8'h5A);
    wr_reg(8'h42, 8'h00);
    cfg({8{3'h3}});
    // Each threshold type on input nine; another type must not trip it.
    for (int t = 0; t < 3; t++) begin
      wr_reg(8'h36, 8'h00);
      wr_reg(8'h37, 8'h81 | (8'h10 << t));
      {ew, uv, ov} = 36'h100 << (12 * t);
      settle();
      chk("fault_a", 8'h01, {7'h0, fa});
      chk("a pins", 8'h7B, po);
      {ew, uv, ov} = 36'h100 << (12 * ((t + 1) % 3));
      settle();
      chk("fault_a off", 8'h00, {7'h0, fa});
    end
    wr_reg(8'h36, 8'h81);
    wr_reg(8'h37, 8'h10);
    {ew, uv, ov} = 36'h080;
    settle();
    chk("a low", 8'h00, po);
    wr_reg(8'h3A, 8'h01);
    {ov, oc2, pu} = 14'h0003;
    settle();
    chk("oc fault_a", 8'h01, {7'h0, fa});
    chk("pwrup pins", 8'h84, po);
    chk("any_fault_n", 8'h00, {7'h0, afn});
    cfg({8{3'h2}});
    wr_reg(8'h3A, 8'h02);
    wr_reg(8'h38, 8'h80);
    wr_reg(8'h39, 8'hA0);
    {oc2, pu, uv} = 14'h0080;
    settle();
    chk("fault_b", 8'h01, {7'h0, fb});
    chk("b pins", 8'hFF, po);
    wr_reg(8'h38, 8'h00);
    wr_reg(8'h39, 8'h44);
    {ew, uv} = 24'h40_0000;
    settle();
    chk("b low", 8'h00, po);
    {ew, oc2} = 13'h0001;
    settle();
    chk("oc fault_b", 8'h01, {7'h0, fb});
    cfg({8{3'h4}});
    {oc2, r2, sf} = 3'b011;
    settle();
    chk("any pins", 8'hA2, po);
    chk("faults no sf", 8'h00, {6'h0, fa, fb});
    sf = 1'b0;
    settle();
    chk("any idle", 8'hFF, po);
    cfg({8{3'h5}});
    oc1 = 1'b1;
    settle();
    chk("oc pins", 8'h00, po);
    {oc1, oc2} = 2'b01;
    settle();
    chk("oc2 pins", 8'hFF, po);
    cfg({8{3'h6}});
    {oc2, watchdog_out_n, de, dv} = {2'b00, 16'h0400};
    settle();
    chk("wdo oe", 8'hAA, poe);
    chk("wdo lvl", 8'h00, po & poe);
    chk("mr", 8'h00, {7'h0, mrn});
    cfg({8{3'h7}});
    {de, dv} = 16'h7911;
    settle();
    chk("roles", 8'h0D, {4'h0, kick, sen, mgn, xin});
    chk("released", 8'h00, poe & 8'h06);
    {xf, de} = 9'h100;
    settle();
    chk("xf oe", 8'h88, poe & 8'h8E);
    chk("xf lvl", 8'h00, po & 8'h88);
    end_of_test();
  end
endmodule
`default_nettype wire
